/* File: src/dtc_pkg.sv */
// Purpose: constants for the dual timer/counter block
// Assumes: word-aligned AHB-Lite register map, 8-bit registers in low bits
// Notes:   bit layouts follow the classic control/mode byte arrangement
package dtc_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_MODE   = 8'h04;
    localparam logic [7:0] ADDR_T0LO   = 8'h08;
    localparam logic [7:0] ADDR_T0HI   = 8'h0C;
    localparam logic [7:0] ADDR_T1LO   = 8'h10;
    localparam logic [7:0] ADDR_T1HI   = 8'h14;
    localparam logic [7:0] ADDR_ACK    = 8'h18;
    // control register bit positions
    localparam int CTRL_T1_OVF = 7;
    localparam int CTRL_T1_RUN = 6;
    localparam int CTRL_T0_OVF = 5;
    localparam int CTRL_T0_RUN = 4;
    localparam int CTRL_X1_FLG = 3;
    localparam int CTRL_X1_TYP = 2;
    localparam int CTRL_X0_FLG = 1;
    localparam int CTRL_X0_TYP = 0;
    // mode register: timer 1 in the upper nibble, timer 0 in the lower
    localparam int MODE_GATE   = 3;
    localparam int MODE_CT     = 2;
    localparam int MODE_T1_LSB = 4;
    // vector acknowledge bits (write one)
    localparam int ACK_T0 = 0;
    localparam int ACK_X0 = 1;
    localparam int ACK_T1 = 2;
    localparam int ACK_X1 = 3;
    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] CNT_RST  = 8'h00;
    // prescaler
    localparam int PRESC_DIV = 32;
    localparam int PRESC_W   = 5;
    // timer modes
    typedef enum logic [1:0] {
        MD_PRESC8 = 2'b00,
        MD_FULL16 = 2'b01,
        MD_RELOAD = 2'b10,
        MD_SPLIT  = 2'b11
    } dtc_mode_t;
endpackage : dtc_pkg

/* File: src/dtc_edge_det.sv */
// Purpose: rise/fall detector on a synchronous pin input
// Assumes: pin already synchronous to sys_clk
// Notes:   first sample after reset taken as high (idle level)
`timescale 1ns/100ps
`default_nettype none
module dtc_edge_det (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic arst_n,
    // pin
    input  wire logic pin_in,
    // edges
    output logic      rise,
    output logic      fall
);
    typedef struct packed {
        logic prev;
    } dtc_edge_st_t;

    dtc_edge_st_t st_ff;
    dtc_edge_st_t nxt_st;

    always_comb begin
        nxt_st      = st_ff;
        nxt_st.prev = pin_in;
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= '{prev: 1'b1};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rise = pin_in & ~st_ff.prev;
    assign fall = ~pin_in & st_ff.prev;
endmodule // dtc_edge_det
`default_nettype wire

/* File: src/dtc_presc.sv */
// Purpose: divide-by-N tick prescaler for 8-bit prescaled mode
// Assumes: one input tick per cycle at most
// Notes:   cleared when the timer leaves the prescaled mode
`timescale 1ns/100ps
`default_nettype none
module dtc_presc
    import dtc_pkg::*;
#(
    parameter int DIV = PRESC_DIV
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic arst_n,
    // control
    input  wire logic clr,
    input  wire logic tick_in,
    // output
    output logic      tick_out
);
    typedef struct packed {
        logic [PRESC_W-1:0] cnt;
    } dtc_presc_st_t;

    localparam logic [PRESC_W-1:0] LAST = PRESC_W'(DIV - 1);

    dtc_presc_st_t st_ff;
    dtc_presc_st_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (clr) begin
            nxt_st.cnt = '0;
        end else if (tick_in) begin
            nxt_st.cnt = (st_ff.cnt == LAST) ? '0 : st_ff.cnt + 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= '{cnt: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tick_out = tick_in & ~clr & (st_ff.cnt == LAST);
endmodule // dtc_presc
`default_nettype wire

/* File: src/dtc_timer.sv */
// Purpose: two 16-bit timer/counters with external interrupt edge flags
// Assumes: pins synchronous to sys_clk; AHB-Lite single word transfers
// Notes:   zero-wait-state slave; flags cleared by vector acknowledge, external flags in edge mode only
//
// Functional notes
// - timer 1 overflow sets its flag, except in timer 0 mode 11 where the timer 0 high byte sets it; vectoring clears it.
// - timer 0 overflow sets its flag; vectoring clears it.
// - timer 1 counts only while its run bit is set.
// - timer 0 counts only while its run bit is set, except its mode 11 high byte, which counts on the timer 1 run bit.
// - external interrupt 1 flag set on either edge; cleared when processed.
// - type bit 1 selects edge or low-level triggering.
// - external interrupt 0 flag set on edge; cleared when processed.
// - type bit 0 selects falling edge or low-level triggering.
// - timer 0 count is 16 bits as high and low byte registers.
// - timer 1 count is 16 bits as high and low byte registers.
// - mode 00 gives an 8-bit counter behind a divide-by-32 prescaler.
// - mode 01 gives a full 16-bit timer or counter.
// - mode 10 counts low byte, reloading from high byte on overflow.
// - timer 1 mode 11 stops timer 1 regardless of run bit.
// - mode register holds a gating bit for timer 1.
// - mode register holds a gating bit for timer 0.
// - timer 0 has its own mode field; reload from its high byte.
// - timer 0 mode 11 splits into two 8-bit counters.
`timescale 1ns/100ps
`default_nettype none
module dtc_timer
    import dtc_pkg::*;
#(
    parameter int PRESC = PRESC_DIV
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // pins
    input  wire logic        ext_irq0_n,
    input  wire logic        ext_irq1_n,
    input  wire logic        cnt_evt0,
    input  wire logic        cnt_evt1,
    // processor vectoring
    input  wire logic        vec_ack_t0,
    input  wire logic        vec_ack_t1,
    input  wire logic        vec_ack_x0,
    input  wire logic        vec_ack_x1,
    // interrupt requests
    output logic             irq_t0,
    output logic             irq_t1,
    output logic             irq_x0,
    output logic             irq_x1
);
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] mode;
        logic [7:0] t0lo;
        logic [7:0] t0hi;
        logic [7:0] t1lo;
        logic [7:0] t1hi;
        logic       dp_wr;
        logic [7:0] dp_addr;
        logic [7:0] rdata;
    } dtc_state_t;

    dtc_state_t st_ff;
    dtc_state_t nxt_st;

    // per-timer count enable: run, gate, mode, source
    function automatic logic cnt_enable(
        input logic run,
        input logic gate,
        input logic pin_n,
        input logic ct,
        input logic evt_fall
    );
        logic ok;
        ok = run & (~gate | pin_n);
        return ok & (ct ? evt_fall : 1'b1);
    endfunction

    // 8-bit increment with wrap indication
    function automatic logic [8:0] inc8(input logic [7:0] v);
        return {1'b0, v} + 9'h001;
    endfunction

    // pin edge detection
    logic x0_rise;
    logic x0_fall;
    logic x1_rise;
    logic x1_fall;
    logic e0_fall;
    logic e1_fall;

    dtc_edge_det u_ed_x0 (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .pin_in  (ext_irq0_n),
        .rise    (x0_rise),
        .fall    (x0_fall)
    );

    dtc_edge_det u_ed_x1 (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .pin_in  (ext_irq1_n),
        .rise    (x1_rise),
        .fall    (x1_fall)
    );

    dtc_edge_det u_ed_e0 (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .pin_in  (cnt_evt0),
        .rise    (),
        .fall    (e0_fall)
    );

    dtc_edge_det u_ed_e1 (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .pin_in  (cnt_evt1),
        .rise    (),
        .fall    (e1_fall)
    );

    dtc_mode_t md0;
    dtc_mode_t md1;
    logic      en0;
    logic      en1;
    logic      en0_hi;
    logic      tk0;
    logic      tk1;
    logic      pclr0;
    logic      pclr1;

    assign md0 = dtc_mode_t'(st_ff.mode[1:0]);
    assign md1 = dtc_mode_t'(st_ff.mode[MODE_T1_LSB+1:MODE_T1_LSB]);
    assign en0 = cnt_enable(st_ff.ctrl[CTRL_T0_RUN], st_ff.mode[MODE_GATE],
                            ext_irq0_n, st_ff.mode[MODE_CT], e0_fall);
    assign en1 = cnt_enable(st_ff.ctrl[CTRL_T1_RUN],
                            st_ff.mode[MODE_T1_LSB+MODE_GATE], ext_irq1_n,
                            st_ff.mode[MODE_T1_LSB+MODE_CT], e1_fall)
                 & (md1 != MD_SPLIT);
    // split high half: internal ticks gated by timer 1 run bit
    assign en0_hi = st_ff.ctrl[CTRL_T1_RUN];
    assign pclr0  = (md0 != MD_PRESC8);
    assign pclr1  = (md1 != MD_PRESC8);

    dtc_presc #(
        .DIV (PRESC)
    ) u_ps0 (
        .sys_clk  (sys_clk),
        .arst_n   (arst_n),
        .clr      (pclr0),
        .tick_in  (en0),
        .tick_out (tk0)
    );

    dtc_presc #(
        .DIV (PRESC)
    ) u_ps1 (
        .sys_clk  (sys_clk),
        .arst_n   (arst_n),
        .clr      (pclr1),
        .tick_in  (en1),
        .tick_out (tk1)
    );

    // bus address phase
    logic ap_valid;
    assign ap_valid = hsel & hready & htrans[1];

    // one timer step; returns {ovf, hi, lo}
    function automatic logic [16:0] step(
        input dtc_mode_t  md,
        input logic       en,
        input logic       ptick,
        input logic [7:0] hi,
        input logic [7:0] lo
    );
        logic [8:0]  l;
        logic [16:0] w;
        l = inc8(lo);
        w = {1'b0, hi, lo};
        unique case (md)
            MD_PRESC8: begin
                if (ptick) begin
                    w = {l[8], hi, l[7:0]};
                end
            end
            MD_FULL16: begin
                if (en) begin
                    w = {1'b0, hi, lo} + 17'h00001;
                end
            end
            MD_RELOAD: begin
                if (en) begin
                    w = {l[8], hi, l[8] ? hi : l[7:0]};
                end
            end
            MD_SPLIT: begin
                if (en) begin
                    w = {l[8], hi, l[7:0]};
                end
            end
        endcase
        return w;
    endfunction

    logic [16:0] s0;
    logic [16:0] s1;
    logic [8:0]  s0_hi;
    logic        x0_evt;
    logic        x1_evt;

    assign s0    = step(md0, en0, tk0, st_ff.t0hi, st_ff.t0lo);
    assign s1    = step(md1, en1, tk1, st_ff.t1hi, st_ff.t1lo);
    assign s0_hi = inc8(st_ff.t0hi);
    assign x0_evt = st_ff.ctrl[CTRL_X0_TYP] ? x0_fall : ~ext_irq0_n;
    assign x1_evt = st_ff.ctrl[CTRL_X1_TYP] ? (x1_fall | x1_rise)
                                            : ~ext_irq1_n;

    always_comb begin
        logic t1_ovf;
        logic t0_ovf;
        logic wr;
        t1_ovf = 1'b0;
        t0_ovf = 1'b0;
        wr     = st_ff.dp_wr;
        nxt_st = st_ff;
        // counting
        {t0_ovf, nxt_st.t0hi, nxt_st.t0lo} = s0;
        {t1_ovf, nxt_st.t1hi, nxt_st.t1lo} = s1;
        if (md0 == MD_SPLIT) begin
            if (en0_hi) begin
                nxt_st.t0hi = s0_hi[7:0];
            end
            t1_ovf = en0_hi & s0_hi[8];
        end
        // vector acknowledge clears, then hardware sets win
        if (vec_ack_t0) begin
            nxt_st.ctrl[CTRL_T0_OVF] = 1'b0;
        end
        if (vec_ack_t1) begin
            nxt_st.ctrl[CTRL_T1_OVF] = 1'b0;
        end
        if (vec_ack_x0 && st_ff.ctrl[CTRL_X0_TYP]) begin
            nxt_st.ctrl[CTRL_X0_FLG] = 1'b0;
        end
        if (vec_ack_x1 && st_ff.ctrl[CTRL_X1_TYP]) begin
            nxt_st.ctrl[CTRL_X1_FLG] = 1'b0;
        end
        // register writes (data phase)
        if (wr) begin
            unique case (st_ff.dp_addr)
                ADDR_CTRL: nxt_st.ctrl = hwdata[7:0];
                ADDR_MODE: nxt_st.mode = hwdata[7:0];
                ADDR_T0LO: nxt_st.t0lo = hwdata[7:0];
                ADDR_T0HI: nxt_st.t0hi = hwdata[7:0];
                ADDR_T1LO: nxt_st.t1lo = hwdata[7:0];
                ADDR_T1HI: nxt_st.t1hi = hwdata[7:0];
                ADDR_ACK: begin
                    if (hwdata[ACK_T0]) begin
                        nxt_st.ctrl[CTRL_T0_OVF] = 1'b0;
                    end
                    if (hwdata[ACK_X0]) begin
                        nxt_st.ctrl[CTRL_X0_FLG] = 1'b0;
                    end
                    if (hwdata[ACK_T1]) begin
                        nxt_st.ctrl[CTRL_T1_OVF] = 1'b0;
                    end
                    if (hwdata[ACK_X1]) begin
                        nxt_st.ctrl[CTRL_X1_FLG] = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // hardware sets win over any clear in the same cycle
        if (t0_ovf) begin
            nxt_st.ctrl[CTRL_T0_OVF] = 1'b1;
        end
        if (t1_ovf) begin
            nxt_st.ctrl[CTRL_T1_OVF] = 1'b1;
        end
        // level mode: flag follows the pin, not latched
        if (st_ff.ctrl[CTRL_X0_TYP]) begin
            if (x0_evt) nxt_st.ctrl[CTRL_X0_FLG] = 1'b1;
        end else begin
            nxt_st.ctrl[CTRL_X0_FLG] = x0_evt;
        end
        if (st_ff.ctrl[CTRL_X1_TYP]) begin
            if (x1_evt) nxt_st.ctrl[CTRL_X1_FLG] = 1'b1;
        end else begin
            nxt_st.ctrl[CTRL_X1_FLG] = x1_evt;
        end
        // address phase capture; read data sampled here for next cycle
        nxt_st.dp_wr   = ap_valid & hwrite;
        nxt_st.dp_addr = haddr;
        nxt_st.rdata   = 8'h00;
        if (ap_valid && !hwrite) begin
            unique case (haddr)
                ADDR_CTRL: nxt_st.rdata = st_ff.ctrl;
                ADDR_MODE: nxt_st.rdata = st_ff.mode;
                ADDR_T0LO: nxt_st.rdata = st_ff.t0lo;
                ADDR_T0HI: nxt_st.rdata = st_ff.t0hi;
                ADDR_T1LO: nxt_st.rdata = st_ff.t1lo;
                ADDR_T1HI: nxt_st.rdata = st_ff.t1hi;
                default:   nxt_st.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= '{ctrl: CTRL_RST, mode: MODE_RST, t0lo: CNT_RST, t0hi: CNT_RST,
                       t1lo: CNT_RST, t1hi: CNT_RST, dp_wr: 1'b0, dp_addr: 8'h00,
                       rdata: 8'h00};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign hrdata    = {24'h000000, st_ff.rdata};
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign irq_t0    = st_ff.ctrl[CTRL_T0_OVF];
    assign irq_t1    = st_ff.ctrl[CTRL_T1_OVF];
    assign irq_x0    = st_ff.ctrl[CTRL_X0_FLG];
    assign irq_x1    = st_ff.ctrl[CTRL_X1_FLG];

    logic unused_ok;
    assign unused_ok = ^{hsize, hwdata[31:8], x0_rise};
endmodule // dtc_timer
`default_nettype wire

/* File: dv/dtc_pins_model.sv */
// Purpose: far-side model of the two counter event pins
// Assumes: one go pulse per event, pulses at least four cycles apart
// Notes:   pins idle high; an event is a low of two cycles
`timescale 1ns/100ps
`default_nettype none
module dtc_pins_model (
    // clock
    input  wire logic       sys_clk,
    // event requests from the bench
    input  wire logic [1:0] evt_go,
    // event pins
    output logic            cnt_evt0,
    output logic            cnt_evt1
);
    logic [1:0] low0_ff = 2'h0;
    logic [1:0] low1_ff = 2'h0;
    // two low cycles so no sampling edge can miss the fall
    always @(posedge sys_clk) begin
        low0_ff <= evt_go[0] ? 2'h2 : low0_ff - 2'(low0_ff != 2'h0);
        low1_ff <= evt_go[1] ? 2'h2 : low1_ff - 2'(low1_ff != 2'h0);
    end
    assign cnt_evt0 = (low0_ff == 2'h0);
    assign cnt_evt1 = (low1_ff == 2'h0);
endmodule // dtc_pins_model
`default_nettype wire

/* File: dv/dtc_timer_properties.sv */
// Purpose: port assertions for the dual timer block
// Assumes: the bench never writes ones into flag bits
// Notes:   flag causes are looked for a few cycles back
`timescale 1ns/100ps
`default_nettype none
module dtc_timer_properties
    import dtc_pkg::*;
(
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        arst_n,
    // bus
    input wire logic        hsel,
    input wire logic [7:0]  haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // pins and flags
    input wire logic        ext_irq0_n,
    input wire logic        ext_irq1_n,
    input wire logic        vec_ack_t0,
    input wire logic        vec_ack_t1,
    input wire logic        vec_ack_x0,
    input wire logic        irq_t0,
    input wire logic        irq_t1,
    input wire logic        irq_x0,
    input wire logic        irq_x1
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    wire logic req    = hsel && hready && htrans[1];
    wire logic wr_req = req && hwrite;
    // ack word and holes have nothing readable
    sequence s_hole_rd;
        req && !hwrite && haddr >= ADDR_ACK;
    endsequence
    sequence s_x1_moved;
        $past(ext_irq1_n, 1) != $past(ext_irq1_n, 4) || !$past(ext_irq1_n, 1);
    endsequence
    ready_okay_a: assert property (hreadyout && !hresp)
        else $error("slave not ready or not okay");
    rdata_upper_a: assert property (hrdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    hole_reads_zero_a: assert property (s_hole_rd |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    x0_set_cause_a: assert property ($rose(irq_x0) |-> !$past(ext_irq0_n, 1)
        || !$past(ext_irq0_n, 2) || !$past(ext_irq0_n, 3)) else $error("x0 flag, pin high");
    x1_set_cause_a: assert property ($rose(irq_x1) |-> s_x1_moved)
        else $error("x1 flag without pin change");
    t0_clear_cause_a: assert property ($fell(irq_t0) |-> $past(vec_ack_t0)
        || $past(wr_req, 2)) else $error("t0 flag lost without ack");
    t1_clear_cause_a: assert property ($fell(irq_t1) |-> $past(vec_ack_t1)
        || $past(wr_req, 2)) else $error("t1 flag lost without ack");
    x0_clear_cause_a: assert property ($fell(irq_x0) |-> $past(vec_ack_x0)
        || $past(ext_irq0_n) || $past(wr_req, 2)) else $error("x0 flag lost");
endmodule // dtc_timer_properties
`default_nettype wire

/* File: dv/dtc_timer_tb.sv */
// Purpose: self-checking bench for the dual timer block
// Assumes: zero-wait slave; reads compared in their data phase
// Notes:   exact counts come from events, clock counts only bounded
`timescale 1ns/100ps
`default_nettype none
module dtc_timer_tb
    import dtc_pkg::*;
;
    logic        sys_clk = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, dph = 1'b0;
    logic        ext_irq0_n = 1'b1, ext_irq1_n = 1'b1;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0, evt_go = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [3:0]  vack = 4'h0;
    logic [31:0] hwdata = 32'h0, hrdata, exp_q[$];
    logic        hreadyout, hresp, cnt_evt0, cnt_evt1;
    wire logic [3:0] irq;
    int          err_total = 0, tests_run = 0;
    dtc_timer u_dtc_timer (.sys_clk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .ext_irq0_n, .ext_irq1_n,
        .cnt_evt0, .cnt_evt1, .vec_ack_t0(vack[0]), .vec_ack_t1(vack[1]),
        .vec_ack_x0(vack[2]), .vec_ack_x1(vack[3]), .irq_t0(irq[0]), .irq_t1(irq[1]),
        .irq_x0(irq[2]), .irq_x1(irq[3]));
    dtc_pins_model u_dtc_pins_model (.sys_clk, .evt_go, .cnt_evt0, .cnt_evt1);
    initial forever #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) dph <= hsel && htrans[1] && !hwrite && hreadyout;
    // taken at the edge that closes the data phase, before the slave updates
    always @(posedge sys_clk)
        if (dph && exp_q.size() > 0) cmp(hrdata, exp_q.pop_front());
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("compared %0d, mismatched %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
            if (n > 20) begin err_total++; print_verdict(); end
        end while (hreadyout !== 1'b1);
    endtask
    // a read notes its expected low byte, passed in d
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        if (!w) exp_q.push_back({24'h0, d[7:0]});
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= w ? d : $urandom;
        wait_rdy();
    endtask
    // interrupt lines have their own compare, mid-cycle where settled
    task automatic chk(input int i, input logic v);
        @(negedge sys_clk);
        tests_run++;
        if (irq[i] !== v) begin
            err_total++;
            $display("[ERR] %0t irq %0d got %h exp %h", $time, i, irq[i], v);
        end
        @(posedge sys_clk);
    endtask
    task automatic waitf(input int i, input logic v, input int lim);
        int n;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
            if (n > lim) begin err_total++; print_verdict(); end
        end while (irq[i] !== v);
        chk(i, v);
    endtask
    task automatic ack(input int i, input logic v);
        vack[i] <= 1'b1;
        @(posedge sys_clk);
        vack[i] <= 1'b0;
        chk(i, v);
    endtask
    task automatic ev(input int ch, input int n);
        repeat (n) begin
            evt_go[ch] <= 1'b1;
            @(posedge sys_clk);
            evt_go[ch] <= 1'b0;
            repeat (6) @(posedge sys_clk);
        end
    endtask
    initial begin
        logic [31:0] v;
        void'($urandom(32'hA2E0AA88));
        repeat (5) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        for (int a = 0; a < 8; a++) xfer(8'(a * 4), 1'b0, 32'h0);
        $display("reset values done");
        for (int a = 1; a < 6; a++) begin
            v = $urandom;
            xfer(8'(a * 4), 1'b1, v);
            xfer(8'(a * 4), 1'b0, v);
        end
        xfer(8'h1C, 1'b1, $urandom);
        xfer(8'h1C, 1'b0, 32'h0);
        $display("register access done");
        xfer(ADDR_MODE, 1'b1, 32'h01);
        xfer(ADDR_T0HI, 1'b1, 32'hFF);
        xfer(ADDR_T0LO, 1'b1, 32'hF0);
        xfer(ADDR_CTRL, 1'b1, 32'h10);
        waitf(0, 1'b1, 60);
        ack(0, 1'b0);
        xfer(ADDR_CTRL, 1'b1, 32'h00);
        xfer(ADDR_T0HI, 1'b0, 32'h00);
        $display("wide overflow done");
        xfer(ADDR_MODE, 1'b1, 32'h00);
        xfer(ADDR_T1LO, 1'b1, 32'hFD);
        xfer(ADDR_T1HI, 1'b1, 32'h00);
        xfer(ADDR_CTRL, 1'b1, 32'h40);
        repeat (30) @(posedge sys_clk);
        chk(1, 1'b0);
        waitf(1, 1'b1, 100);
        ack(1, 1'b0);
        xfer(ADDR_CTRL, 1'b1, 32'h00);
        xfer(ADDR_T1HI, 1'b0, 32'h00);
        $display("prescaled mode done");
        xfer(ADDR_MODE, 1'b1, 32'h60);
        xfer(ADDR_T1HI, 1'b1, 32'hA5);
        xfer(ADDR_T1LO, 1'b1, 32'hFF);
        ev(1, 1);
        xfer(ADDR_T1LO, 1'b0, 32'hFF);
        xfer(ADDR_CTRL, 1'b1, 32'h40);
        ev(1, 3);
        xfer(ADDR_T1LO, 1'b0, 32'hA7);
        xfer(ADDR_T1HI, 1'b0, 32'hA5);
        ack(1, 1'b0);
        xfer(ADDR_MODE, 1'b1, 32'h70);
        ev(1, 2);
        xfer(ADDR_T1LO, 1'b0, 32'hA7);
        $display("reload and stop done");
        xfer(ADDR_CTRL, 1'b1, 32'h00);
        xfer(ADDR_MODE, 1'b1, 32'h0D);
        xfer(ADDR_T0LO, 1'b1, 32'h00);
        xfer(ADDR_CTRL, 1'b1, 32'h10);
        ext_irq0_n <= 1'b0;
        ev(0, 2);
        ext_irq0_n <= 1'b1;
        ev(0, 3);
        xfer(ADDR_T0LO, 1'b0, 32'h03);
        $display("gated counting done");
        xfer(ADDR_CTRL, 1'b1, 32'h00);
        xfer(ADDR_MODE, 1'b1, 32'h06);
        xfer(ADDR_T0HI, 1'b1, 32'h3C);
        xfer(ADDR_T0LO, 1'b1, 32'hFE);
        xfer(ADDR_CTRL, 1'b1, 32'h10);
        ev(0, 3);
        xfer(ADDR_T0LO, 1'b0, 32'h3D);
        chk(0, 1'b1);
        xfer(ADDR_ACK, 1'b1, 32'h01);
        chk(0, 1'b0);
        xfer(ADDR_CTRL, 1'b1, 32'h00);
        xfer(ADDR_MODE, 1'b1, 32'h07);
        xfer(ADDR_T0LO, 1'b1, 32'h10);
        xfer(ADDR_T0HI, 1'b1, 32'hF8);
        xfer(ADDR_CTRL, 1'b1, 32'h40);
        ev(0, 1);
        waitf(1, 1'b1, 20);
        ack(1, 1'b0);
        xfer(ADDR_CTRL, 1'b1, 32'h00);
        xfer(ADDR_T0LO, 1'b0, 32'h10);
        xfer(ADDR_MODE, 1'b1, 32'hE0);
        xfer(ADDR_T1LO, 1'b1, 32'h20);
        xfer(ADDR_CTRL, 1'b1, 32'h40);
        ext_irq1_n <= 1'b0;
        ev(1, 2);
        ext_irq1_n <= 1'b1;
        ev(1, 1);
        xfer(ADDR_T1LO, 1'b0, 32'h21);
        $display("reload, split and gate done");
        xfer(ADDR_CTRL, 1'b1, 32'h05);
        ext_irq0_n <= 1'b0;
        waitf(2, 1'b1, 10);
        ack(2, 1'b0);
        ext_irq0_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        chk(2, 1'b0);
        for (int k = 0; k < 2; k++) begin
            ext_irq1_n <= k[0];
            waitf(3, 1'b1, 10);
            ack(3, 1'b0);
        end
        xfer(ADDR_CTRL, 1'b1, 32'h00);
        ext_irq0_n <= 1'b0;
        waitf(2, 1'b1, 10);
        ack(2, 1'b1);
        ext_irq0_n <= 1'b1;
        waitf(2, 1'b0, 10);
        $display("external interrupts done");
        print_verdict();
    end
endmodule // dtc_timer_tb
bind dtc_timer dtc_timer_properties u_dtc_timer_properties (.sys_clk, .arst_n, .hsel,
    .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .ext_irq0_n,
    .ext_irq1_n, .vec_ack_t0, .vec_ack_t1, .vec_ack_x0, .irq_t0, .irq_t1, .irq_x0, .irq_x1);
`default_nettype wire
